// *** burst_sched_pkg.sv ***
// Shared constants and carriers for the test-mode burst scheduler.
// Assumes a single 20 MHz clock domain and an APB register port.
package burst_sched_pkg;

    // Multiframe geometry
    localparam logic [2:0] SLOTS_PER_FRAME = 3'h4;
    localparam logic [4:0] FRAMES_PER_MF   = 5'h12;
    localparam logic [4:0] CTRL_FRAME      = 5'h12;
    localparam logic [4:0] LAST_TRAF_FRAME = 5'h11;
    localparam logic [2:0] FIRST_SLOT      = 3'h1;
    localparam logic [1:0] BLCH_MF_SPACING = 2'h3;

    // Scrambling seed width and pseudo random sequence
    localparam int         SEED_W          = 30;
    localparam logic [29:0] BSCH_SEED      = 30'h0;
    localparam logic [8:0]  PRBS_SEED      = 9'h1ff;
    localparam logic [8:0]  PRBS_PERIOD    = 9'h1ff;

    // Default configuration values
    localparam logic [3:0] DEF_CHAN_TYPE   = 4'h1;
    localparam logic [7:0] DEF_MAX_TX_PWR  = 8'h0f;
    localparam logic [7:0] DEF_ACCESS_THR  = 8'hcb;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] CFG_OFS         = 8'h04;
    localparam logic [7:0] COLOUR_OFS      = 8'h08;
    localparam logic [7:0] STATUS_OFS      = 8'h0c;
    localparam logic [7:0] RXDATA_OFS      = 8'h10;
    localparam logic [7:0] BCAST_OFS       = 8'h14;
    localparam logic [7:0] PRBS_OFS        = 8'h18;
    localparam logic [7:0] TXPWR_OFS       = 8'h1c;
    localparam logic [31:0] CTRL_RST       = 32'h0;

    // Burst and channel kinds driven per slot
    typedef enum logic [2:0]
    {
        BURST_NONE    = 3'h0,
        BURST_SYNC    = 3'h1,
        BURST_NORMAL  = 3'h2,
        BURST_CONTROL = 3'h3,
        BURST_CLCH    = 3'h4,
        BURST_BLCH    = 3'h5
    } burst_e;

    // Timing position in the multiframe
    typedef struct packed
    {
        logic [4:0] frame;
        logic [2:0] slot;
    } slot_pos_s;

    // Decoded broadcast test channel contents
    typedef struct packed
    {
        logic       txOn;
        logic       txBurstControl;
        logic [3:0] expectedChannelSelector;
        logic [7:0] powerCtrl;
        logic [15:0] carrierInfo;
    } bcast_s;

    // One scheduled slot
    typedef struct packed
    {
        burst_e     burst;
        logic [3:0] chanType;
        logic       useZeroSeed;
        logic       payloadPrbs;
    } slot_plan_s;

endpackage : burst_sched_pkg

// *** prbs511.sv ***
// Nine-stage pseudo random generator with period 511, x^9 + x^5 + 1.
// Assumes the caller advances it only on payload bits it really sends.
`timescale 1ns/1ns
module prbs511
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       advance,
    // Output
    output logic            bitOut,
    output logic [8:0]      state
);
    import burst_sched_pkg::*;

    logic [8:0] lfsr_reg;

    // Shift only when told, so skipped slots leave the sequence intact
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lfsr_reg <= PRBS_SEED;
        else if (advance)
            lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
    end

    assign bitOut = lfsr_reg[8];
    assign state  = lfsr_reg;

endmodule : prbs511

// *** radio_test_mode_burst_scheduler.sv ***
// Test-mode slot and frame scheduler for a radio station under test.
// Assumes a slot strobe and payload-bit strobe from the air timing logic,
// decoded broadcast channel contents from the receiver, and an APB master.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// - Broadcast flag selects test transmit or receive
// - Receive mode outputs decoded selected channel data
// - Sync slot decodes both channels to connector
// - Bad frame-18 message keeps prior state
// - Base receives configured channel slot 1
// - Base sends sync burst slot 1 frame 18
// - Continuous mode fills listed slots type 1
// - Discontinuous mode only slot 1 frames 1-17
// - Seed from colour code, zero for sync
// - Defaults: type 1, 15 dBm, -53 dBm
// - Fixed duplex capability ignores broadcast carrier info
// - Mobile sends chosen burst, slot 1 only
// - Control burst frame 18, traffic frames 1-17
// - Payload sequence continues, skipping control slots
// - Power from signal strength and broadcast parameters
// - Transmit mode keeps decoding frame-18 broadcast
// - Extra carrier bursts spaced four multiframes, block 2
module radio_test_mode_burst_scheduler
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rstn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Air timing and receiver
    input  wire logic                         slotStrobe,
    input  wire logic                         bitStrobe,
    input  wire logic                         rxDecodeValid,
    input  wire logic                         rxDecodeErr,
    input  wire logic                         rxIsSync,
    input  wire logic [31:0]                  rxDecodeData,
    input  wire burst_sched_pkg::bcast_s      rxBcast,
    input  wire logic [7:0]                   rxSignalStrength,
    // Schedule outputs
    output burst_sched_pkg::slot_pos_s        slotPos,
    output burst_sched_pkg::slot_plan_s       slotPlan,
    output logic [29:0]                       scrambleSeed,
    output logic                              txActive,
    output logic                              payloadBit,
    output logic [7:0]                        txPowerLevel,
    // Test connector
    output logic [31:0]                       testConnData,
    output logic                              testConnValid
);
    import burst_sched_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_reg;      // [0] base station, [1] continuous, [2] base tx, [3] fixed duplex
    logic [31:0] cfg_reg;       // [3:0] channel type, [15:8] max power, [23:16] access threshold
    logic [29:0] colour_reg;
    logic [15:0] carrier_reg;
    logic        txMode_reg;
    logic        txBurstControl_reg;
    logic [3:0]  expectedChannelSelector_reg;
    logic [7:0]  powerCtrl_reg;
    logic [31:0] connData_reg;
    logic        connValid_reg;
    logic [4:0]  frame_reg;
    logic [2:0]  slot_reg;
    logic [1:0]  mfCount_reg;
    logic        blchDue_reg;
    logic [7:0]  txPower_reg;
    logic [31:0] prdata_reg;
    logic [8:0]  prbsState;

    logic isBase;
    logic continuous;
    logic baseTx;
    logic fixedDuplex;
    logic wrEn;
    logic rdEn;
    logic addrOk;
    logic frame18;
    logic slot1;
    slot_plan_s plan;

    assign isBase      = ctrl_reg[0];
    assign continuous  = ctrl_reg[1];
    assign baseTx      = ctrl_reg[2];
    assign fixedDuplex = ctrl_reg[3];
    assign frame18     = (frame_reg == CTRL_FRAME);
    assign slot1       = (slot_reg == FIRST_SLOT);

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, unmapped addresses answer with an error
    assign addrOk  = (paddr[1:0] == 2'h0) && (paddr <= TXPWR_OFS);
    assign wrEn    = psel && penable && pwrite && addrOk;
    assign rdEn    = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addrOk;
    assign prdata  = prdata_reg;

    // Software-writable configuration, defaults apply after reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg   <= CTRL_RST;
            cfg_reg    <= {8'h00, DEF_ACCESS_THR, DEF_MAX_TX_PWR, 4'h0, DEF_CHAN_TYPE};
            colour_reg <= 30'h0;
        end
        else if (wrEn)
        begin
            if (paddr == CTRL_OFS)
                ctrl_reg <= {28'h0, pwdata[3:0]};
            if (paddr == CFG_OFS)
                cfg_reg <= {8'h00, pwdata[23:8], 4'h0, pwdata[3:0]};
            if (paddr == COLOUR_OFS)
                colour_reg <= pwdata[29:0];
        end
    end

    // Read data captured in the setup cycle, so it is stable in access
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prdata_reg <= 32'h0;
        else if (rdEn)
        begin
            unique case (paddr)
                CTRL_OFS:   prdata_reg <= ctrl_reg;
                CFG_OFS:    prdata_reg <= cfg_reg;
                COLOUR_OFS: prdata_reg <= {2'h0, colour_reg};
                STATUS_OFS: prdata_reg <= {22'h0, txMode_reg, frame_reg, slot_reg, txBurstControl_reg};
                RXDATA_OFS: prdata_reg <= connData_reg;
                BCAST_OFS:  prdata_reg <= {12'h0, expectedChannelSelector_reg, carrier_reg};
                PRBS_OFS:   prdata_reg <= {23'h0, prbsState};
                TXPWR_OFS:  prdata_reg <= {24'h0, txPower_reg};
                default:    prdata_reg <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot 1..4 and frame 1..18 counters advance on the slot strobe
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            slot_reg  <= FIRST_SLOT;
            frame_reg <= 5'h01;
        end
        else if (slotStrobe)
        begin
            if (slot_reg == SLOTS_PER_FRAME)
            begin
                slot_reg  <= FIRST_SLOT;
                frame_reg <= (frame_reg == FRAMES_PER_MF) ? 5'h01 : frame_reg + 5'h01;
            end
            else
                slot_reg <= slot_reg + 3'h1;
        end
    end

    // Multiframe count gates carrier bursts to one per four multiframes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mfCount_reg <= 2'h0;
            blchDue_reg <= 1'b1;
        end
        else if (slotStrobe && frame18 && slot_reg == SLOTS_PER_FRAME)
        begin
            mfCount_reg <= mfCount_reg + 2'h1;
            if (mfCount_reg == BLCH_MF_SPACING)
                blchDue_reg <= 1'b1;
        end
        else if (slotStrobe && plan.burst == BURST_BLCH)
            blchDue_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Broadcast state from frame 18; an erroneous message leaves it untouched
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            txMode_reg                  <= 1'b0;
            txBurstControl_reg          <= 1'b0;
            expectedChannelSelector_reg <= DEF_CHAN_TYPE;
            powerCtrl_reg               <= DEF_MAX_TX_PWR;
            carrier_reg                 <= 16'h0;
        end
        else if (!isBase && rxDecodeValid && rxIsSync && frame18 && !rxDecodeErr)
        begin
            // Decoded in both test modes, not only in receive
            txMode_reg                  <= rxBcast.txOn;
            txBurstControl_reg          <= rxBcast.txBurstControl;
            expectedChannelSelector_reg <= rxBcast.expectedChannelSelector;
            powerCtrl_reg               <= rxBcast.powerCtrl;
            // Hard-wired duplex keeps its own carrier plan
            if (!fixedDuplex)
                carrier_reg <= rxBcast.carrierInfo;
        end
    end

    // Test connector: decoded data of the tested channel or broadcast slot
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            connData_reg  <= 32'h0;
            connValid_reg <= 1'b0;
        end
        else
        begin
            connValid_reg <= 1'b0;
            if (rxDecodeValid && !rxDecodeErr)
            begin
                if (!isBase && (rxIsSync || !txMode_reg))
                begin
                    connData_reg  <= rxDecodeData;
                    connValid_reg <= 1'b1;
                end
                else if (isBase && !baseTx && slot1)
                begin
                    connData_reg  <= rxDecodeData;
                    connValid_reg <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot plan for the current position
    always_comb
    begin
        plan = '{burst: BURST_NONE, chanType: 4'h0, useZeroSeed: 1'b0, payloadPrbs: 1'b0};
        if (isBase)
        begin
            if (frame18 && slot1)
                plan = '{burst: BURST_SYNC, chanType: cfg_reg[3:0],
                         useZeroSeed: 1'b1, payloadPrbs: 1'b0};
            else if (continuous || (slot1 && !frame18))
                plan = '{burst: (slot1 && blchDue_reg && baseTx) ? BURST_BLCH : BURST_NORMAL,
                         chanType: DEF_CHAN_TYPE, useZeroSeed: 1'b0, payloadPrbs: 1'b1};
        end
        else if (txMode_reg && slot1)
        begin
            if (frame18)
                plan = '{burst: BURST_CLCH, chanType: 4'h0,
                         useZeroSeed: 1'b0, payloadPrbs: 1'b0};
            else
                plan = '{burst: txBurstControl_reg ? BURST_CONTROL : BURST_NORMAL,
                         chanType: expectedChannelSelector_reg,
                         useZeroSeed: 1'b0, payloadPrbs: 1'b1};
        end
    end

    // Registered plan and seed for the current slot, one clock behind its position
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            slotPlan     <= '{burst: BURST_NONE, chanType: 4'h0, useZeroSeed: 1'b0, payloadPrbs: 1'b0};
            scrambleSeed <= BSCH_SEED;
        end
        else
        begin
            slotPlan     <= plan;
            scrambleSeed <= plan.useZeroSeed ? BSCH_SEED : colour_reg;
        end
    end

    // Transmit power: broadcast limit less received strength, floored at zero; base uses configured maximum
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            txPower_reg <= DEF_MAX_TX_PWR;
        else if (isBase)
            txPower_reg <= cfg_reg[15:8];
        else
            txPower_reg <= (rxSignalStrength < powerCtrl_reg) ? powerCtrl_reg - rxSignalStrength
                                                              : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Payload sequence advances only in payload slots
    prbs511 u_prbs
    (
        .clk     (clk),
        .rstn    (rstn),
        .advance (bitStrobe && plan.payloadPrbs),
        .bitOut  (payloadBit),
        .state   (prbsState)
    );

    assign slotPos       = '{frame: frame_reg, slot: slot_reg};
    assign txActive      = (slotPlan.burst != BURST_NONE);
    assign txPowerLevel  = txPower_reg;
    assign testConnData  = connData_reg;
    assign testConnValid = connValid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_frame_wrap;
        @(posedge clk) disable iff (!rstn)
        slotStrobe && frame18 && slot_reg == SLOTS_PER_FRAME |=> frame_reg == 5'h01 && slot1;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

    property p_sync_seed;
        @(posedge clk) disable iff (!rstn)
        isBase && frame18 && slot1 |=> slotPlan.burst == BURST_SYNC && scrambleSeed == 30'h0;
    endproperty
    a_sync_seed: assert property (p_sync_seed) else $error("sync burst seed wrong");

    property p_seed_colour;
        @(posedge clk) disable iff (!rstn)
        !plan.useZeroSeed |=> scrambleSeed == $past(colour_reg);
    endproperty
    a_seed_colour: assert property (p_seed_colour) else $error("seed not colour code");

    property p_disc_slot;
        @(posedge clk) disable iff (!rstn)
        isBase && !continuous && !slot1 |=> slotPlan.burst == BURST_NONE;
    endproperty
    a_disc_slot: assert property (p_disc_slot) else $error("discontinuous slot used");

    property p_cont_fill;
        @(posedge clk) disable iff (!rstn)
        isBase && continuous && !(frame18 && slot1) |=> slotPlan.chanType == 4'h1;
    endproperty
    a_cont_fill: assert property (p_cont_fill) else $error("continuous fill wrong");

    property p_ms_slot1;
        @(posedge clk) disable iff (!rstn)
        !isBase && !slot1 |=> slotPlan.burst == BURST_NONE;
    endproperty
    a_ms_slot1: assert property (p_ms_slot1) else $error("mobile sent off slot 1");

    property p_clch;
        @(posedge clk) disable iff (!rstn)
        !isBase && txMode_reg && frame18 && slot1 |=> slotPlan.burst == BURST_CLCH;
    endproperty
    a_clch: assert property (p_clch) else $error("frame 18 burst wrong");

    property p_err_hold;
        @(posedge clk) disable iff (!rstn)
        rxDecodeValid && rxDecodeErr |=> $stable(txMode_reg) && $stable(powerCtrl_reg);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("bad message changed state");

    property p_prbs_hold;
        @(posedge clk) disable iff (!rstn)
        !plan.payloadPrbs |=> prbsState == $past(prbsState);
    endproperty
    a_prbs_hold: assert property (p_prbs_hold) else $error("sequence moved in idle slot");

    property p_conn;
        @(posedge clk) disable iff (!rstn)
        !isBase && rxDecodeValid && !rxDecodeErr && rxIsSync |=> testConnValid;
    endproperty
    a_conn: assert property (p_conn) else $error("sync data not output");

    c_sync:  cover property (@(posedge clk) disable iff (!rstn) slotPlan.burst == BURST_SYNC);
    c_clch:  cover property (@(posedge clk) disable iff (!rstn) slotPlan.burst == BURST_CLCH);
    c_blch:  cover property (@(posedge clk) disable iff (!rstn) slotPlan.burst == BURST_BLCH);
    c_txon:  cover property (@(posedge clk) disable iff (!rstn) $rose(txMode_reg));

endmodule : radio_test_mode_burst_scheduler

// *** test_system_model.sv ***
// Far-side test system: slot pacing and decoded downlink bursts.
// Assumes the scheduler starts at frame 1 slot 1 after reset.
`timescale 1ns/1ns
module test_system_model
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Bench control
    input  wire logic                    corrupt,
    input  wire burst_sched_pkg::bcast_s bcastIn,
    // Towards the scheduler
    output logic                         slotStrobe,
    output logic                         rxDecodeValid,
    output logic                         rxDecodeErr,
    output logic                         rxIsSync,
    output logic [31:0]                  rxDecodeData,
    output burst_sched_pkg::bcast_s      rxBcast
);
    import burst_sched_pkg::*;
    int cyc;
    int frame;
    int slot;
    ////////////////////////////////////////////////////////////
    // Eight clocks a slot; decode lands mid-slot once position settles
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cyc           <= 0;
            frame         <= 1;
            slot          <= 1;
            slotStrobe    <= 1'b0;
            rxDecodeValid <= 1'b0;
            rxDecodeErr   <= 1'b0;
            rxIsSync      <= 1'b0;
            rxDecodeData  <= 32'h0;
        end
        else
        begin
            cyc        <= (cyc + 1) % 8;
            slotStrobe <= (cyc == 7);
            if (cyc == 7)
            begin
                slot <= slot % 4 + 1;
                if (slot == 4)
                    frame <= frame % 18 + 1;
            end
            rxDecodeValid <= (cyc == 3);
            rxIsSync      <= (cyc == 3) && (slot == 1) && (frame == 18);
            rxDecodeErr   <= (cyc == 3) && corrupt;
            // Idle data toggles so a stale word is never mistaken for output
            rxDecodeData  <= (cyc == 3) ? $urandom : ~rxDecodeData;
        end
    end
    // Broadcast contents travel with every decode
    assign rxBcast = bcastIn;
endmodule : test_system_model

// *** test_radio_test_mode_burst_scheduler.sv ***
// Self-checking bench for the test-mode burst scheduler.
// Assumes the far-side model paces slots at eight clocks each.
`timescale 1ns/1ns
module test_radio_test_mode_burst_scheduler;
    import burst_sched_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        bitStrobe = 1'b0, corrupt = 1'b0, pready, pslverr, txActive, payloadBit;
    logic        slotStrobe, rxDecodeValid, rxDecodeErr, rxIsSync, testConnValid;
    logic [7:0]  paddr = 8'h00, rxSignalStrength = 8'h00, txPowerLevel;
    logic [31:0] pwdata = 32'h0, prdata, rxDecodeData, testConnData, rd, pData;
    logic [29:0] scrambleSeed, colour = 30'h0;
    logic [8:0]  prbs = PRBS_SEED;
    bcast_s      rxBcast, bcastIn = '0;
    slot_pos_s   slotPos;
    slot_plan_s  slotPlan;
    burst_e      kind;
    int          n_errors = 0, checks = 0, f = 1, s = 1, seedDummy;
    logic        isBase = 1'b0, cont = 1'b0, txTest = 1'b0, planChk = 1'b0, act, err;
    logic        expTx = 1'b0, expTbc = 1'b0, pend = 1'b0, pS1, pSync, pErr, pTx;

    always #25 clk = ~clk;

    radio_test_mode_burst_scheduler u_radio_test_mode_burst_scheduler
    (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slotStrobe(slotStrobe), .bitStrobe(bitStrobe),
        .rxDecodeValid(rxDecodeValid), .rxDecodeErr(rxDecodeErr), .rxIsSync(rxIsSync),
        .rxDecodeData(rxDecodeData), .rxBcast(rxBcast), .rxSignalStrength(rxSignalStrength),
        .slotPos(slotPos), .slotPlan(slotPlan), .scrambleSeed(scrambleSeed),
        .txActive(txActive), .payloadBit(payloadBit), .txPowerLevel(txPowerLevel),
        .testConnData(testConnData), .testConnValid(testConnValid)
    );

    test_system_model u_test_system_model
    (
        .clk(clk), .rstn(rstn), .corrupt(corrupt), .bcastIn(bcastIn),
        .slotStrobe(slotStrobe), .rxDecodeValid(rxDecodeValid), .rxDecodeErr(rxDecodeErr),
        .rxIsSync(rxIsSync), .rxDecodeData(rxDecodeData), .rxBcast(rxBcast)
    );
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // One APB transfer; pready is awaited, never assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            n_errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Mode change mutes checks for two slots so the new plan can settle
    task automatic set_mode(input logic b, input logic c, input logic t);
        planChk = 1'b0;
        apb(1'b1, CTRL_OFS, {29'h0, t, c, b});
        isBase = b;
        cont = c;
        txTest = t;
        repeat (16) @(posedge clk);
        planChk = 1'b1;
    endtask : set_mode
    ////////////////////////////////////////////////////////////
    // Bench copy of the slot counters, and random payload strobes
    always @(posedge clk)
    begin
        bitStrobe <= 1'($urandom);
        if (slotStrobe === 1'b1)
        begin
            s <= s % 4 + 1;
            if (s == 4)
                f <= f % 18 + 1;
        end
    end

    // Schedule checked mid-slot; connector checked one clock after a decode
    always @(negedge clk)
    begin
        // Payload sequence copy; the advance is decided from this slot's plan
        if (rstn)
        begin
            chk({31'h0, payloadBit}, {31'h0, prbs[8]}, "payload");
            if (bitStrobe && (isBase ? (cont || s == 1) && !(s == 1 && f == 18)
                                     : expTx && s == 1 && f != 18))
                prbs = {prbs[7:0], prbs[8] ^ prbs[4]};
        end
        if (pend && planChk)
        begin
            act = !pErr && (isBase ? (pS1 && !txTest) : (!pTx || pSync));
            chk({31'h0, testConnValid}, {31'h0, act}, "conn valid");
            if (act)
                chk(testConnData, pData, "conn data");
        end
        pend = (rxDecodeValid === 1'b1);
        if (pend && planChk)
        begin
            chk({24'h0, slotPos}, {24'h0, f[4:0], s[2:0]}, "position");
            act = isBase ? (cont || s == 1) : (expTx && s == 1);
            kind = (isBase && s == 1 && f == 18) ? BURST_SYNC : BURST_NONE;
            if (!isBase && act)
                kind = (f == 18) ? BURST_CLCH : (expTbc ? BURST_CONTROL : BURST_NORMAL);
            if (!(isBase && !txTest))
            begin
                chk({31'h0, txActive}, {31'h0, act}, "active");
                if (!isBase || kind == BURST_SYNC)
                    chk({29'h0, slotPlan.burst}, {29'h0, kind}, "burst");
                if (kind == BURST_SYNC)
                    chk({2'h0, scrambleSeed}, 32'h0, "sync seed");
                else if (isBase && act)
                    chk({2'h0, scrambleSeed}, {2'h0, colour}, "seed");
            end
        end
        if (pend)
        begin
            pS1 = (s == 1);
            pSync = rxIsSync;
            pErr = rxDecodeErr;
            pTx = expTx;
            pData = rxDecodeData;
            if (!isBase && rxIsSync === 1'b1 && rxDecodeErr === 1'b0)
            begin
                expTx = rxBcast.txOn;
                expTbc = rxBcast.txBurstControl;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        seedDummy = $urandom(1);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, CTRL_RST, "ctrl reset");
        apb(1'b0, CFG_OFS, 32'h0);
        chk(rd, 32'h00cb0f01, "cfg defaults");
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        colour = 30'($urandom);
        apb(1'b1, COLOUR_OFS, {2'h0, colour});
        apb(1'b0, COLOUR_OFS, 32'h0);
        chk(rd, {2'h0, colour}, "colour");
        $display("test registers done");
        for (int c = 1; c >= 0; c--)
        begin
            set_mode(1'b1, c[0], 1'b1);
            repeat (600) @(posedge clk);
            chk({24'h0, txPowerLevel}, 32'h0f, "base power");
            $display("test base transmit %0d done", c);
        end
        set_mode(1'b1, 1'b0, 1'b0);
        repeat (600) @(posedge clk);
        $display("test base receive done");
        rxSignalStrength <= 8'($urandom);
        for (int t = 0; t < 2; t++)
        begin
            bcastIn <= {1'b1, t[0], 4'h1, 8'($urandom), 16'($urandom)};
            set_mode(1'b0, 1'b0, 1'b0);
            repeat (1200) @(posedge clk);
        end
        chk({24'h0, txPowerLevel}, {24'h0, (bcastIn.powerCtrl > rxSignalStrength) ?
            bcastIn.powerCtrl - rxSignalStrength : 8'h00}, "power");
        corrupt <= 1'b1;
        bcastIn <= {1'b0, bcastIn[28:0]};
        repeat (600) @(posedge clk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk({31'h0, rd[9]}, 32'h1, "mode kept");
        corrupt <= 1'b0;
        repeat (600) @(posedge clk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk({31'h0, rd[9]}, 32'h0, "mode receive");
        apb(1'b0, BCAST_OFS, 32'h0);
        chk(rd, {12'h0, bcastIn[27:24], bcastIn[15:0]}, "bcast");
        $display("test mobile done");
        finish_test();
    end
endmodule : test_radio_test_mode_burst_scheduler
